// >>> src/spihp_pkg.sv
/*
 * Shared constants and types of the serial host port: address byte layout,
 * strap decoding, register space, host divider and FIFO sizing.
 * Assumes a 40 MHz system clock at both ends.
 */
`default_nettype none

package spihp_pkg;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned ADDR_W = 6;
    localparam int unsigned LEN_W = 6;
    localparam int unsigned RW_BIT = 7;
    localparam int unsigned ADDR_MSB = 6;
    localparam int unsigned ADDR_LSB = 1;
    localparam int unsigned REG_COUNT = 64;
    localparam int unsigned FIFO_DEPTH = 32;
    localparam int unsigned SYS_CLK_HZ = 40_000_000;
    localparam int unsigned MAX_BIT_RATE = 10_000_000;
    localparam int unsigned HALF_DIV = SYS_CLK_HZ / (2 * MAX_BIT_RATE);
    localparam int unsigned STRAP_SETTLE = 3;
    localparam int unsigned STRAP_SEL_BIT = 7;
    localparam int unsigned STRAP_MODE_BIT = 6;
    localparam logic [3:0] I2C_FIXED_HI = 4'h5;
    localparam logic [7:0] READ_END_BYTE = 8'h00;

    typedef enum logic [1:0] {
        SPIHP_IF_NONE,
        SPIHP_IF_UART,
        SPIHP_IF_SPI,
        SPIHP_IF_I2C
    } spihp_iface_e;

    typedef enum logic [1:0] {
        HS_IDLE,
        HS_SHIFT,
        HS_WAIT,
        HS_END
    } spihp_hstate_e;
endpackage

`default_nettype wire

// >>> src/spihp_if.sv
/*
 * Pins between host controller and device port.
 * Assumes the bench drives the straps and the four low port pins; pin seven
 * is pulled up while the device does not drive it.
 */
`default_nettype none

interface spihp_if;
    logic sda_pin;
    logic port_pin_five;
    logic port_pin_six;
    logic seven_drv;
    logic seven_oe;
    logic port_pin_seven;
    logic iface_sel_strap;
    logic address_mode_strap;
    logic [3:0] port_pin_low;

    // Pull-up when released
    assign port_pin_seven = seven_oe ? seven_drv : 1'b1;

    modport device (
        input sda_pin,
        input port_pin_five,
        input port_pin_six,
        input port_pin_seven,
        input iface_sel_strap,
        input address_mode_strap,
        input port_pin_low,
        output seven_drv,
        output seven_oe
    );

    modport host (
        output sda_pin,
        output port_pin_five,
        output port_pin_six,
        input port_pin_seven
    );
endinterface

`default_nettype wire

// >>> src/spihp_fifo.sv
/*
 * Small synchronous FIFO with valid/ready on both sides.
 * Assumes DEPTH is a power of two; one clock for both sides.
 */
`default_nettype none

module spihp_fifo #(
    parameter int unsigned WIDTH = spihp_pkg::BYTE_W,
    parameter int unsigned DEPTH = spihp_pkg::FIFO_DEPTH
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } spihp_fifo_s;

    spihp_fifo_s q;
    spihp_fifo_s next_q;
    logic push;
    logic pop;

    assign in_ready_o = (q.cnt != FULL);
    assign out_valid_o = (q.cnt != '0);
    assign out_data_o = q.mem[q.rp];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    always_comb begin
        next_q = q;
        if (push) begin
            next_q.mem[q.wp] = in_data_i;
            next_q.wp = q.wp + 1'b1;
        end
        if (pop) begin
            next_q.rp = q.rp + 1'b1;
        end
        // Simultaneous push and pop leaves the count alone
        case ({push, pop})
            2'b10: next_q.cnt = q.cnt + 1'b1;
            2'b01: next_q.cnt = q.cnt - 1'b1;
            default: next_q.cnt = q.cnt;
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end
endmodule

`default_nettype wire

// >>> src/spihp_device.sv
/*
 * Device end of the host port: strap detection, serial slave on the link
 * clock, and a 64-byte register space on the system clock.
 * Assumes the host clocks the link at no more than 10 Mbit/s and that the
 * system clock is at least four times the bit rate, so a read request
 * settles before the falling link edge that opens the next byte.
 */
`default_nettype none

module spihp_device (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    spihp_if.device link,
    output var spihp_pkg::spihp_iface_e iface_type_o,
    output logic detect_done_o,
    output logic [6:0] i2c_addr_o,
    output logic wr_strobe_o,
    output logic [spihp_pkg::ADDR_W-1:0] wr_addr_o,
    output logic [spihp_pkg::BYTE_W-1:0] wr_data_o
);
    // ***************************************************************
    // State
    // ***************************************************************
    typedef struct packed {
        logic [7:0] strap_s1;
        logic [7:0] strap_s2;
        logic [1:0] settle;
        logic detected;
        spihp_pkg::spihp_iface_e iface;
        logic spi_on;
        logic [6:0] i2c_addr;
        logic [2:0] rd_sync;
        logic [2:0] wr_sync;
        logic [spihp_pkg::BYTE_W-1:0] rd_word;
        logic [spihp_pkg::REG_COUNT-1:0][spihp_pkg::BYTE_W-1:0] regs;
        logic wr_strobe;
        logic [spihp_pkg::ADDR_W-1:0] wr_addr;
        logic [spihp_pkg::BYTE_W-1:0] wr_data;
    } spihp_core_s;

    // Frame-scoped link state, cleared whenever chip select is high
    typedef struct packed {
        logic [2:0] bit_cnt;
        logic [spihp_pkg::BYTE_W-1:0] shift;
        logic addr_done;
        logic is_read;
        logic [spihp_pkg::ADDR_W-1:0] addr;
    } spihp_ctl_s;

    // Crossing payload; survives chip select so toggles never jump
    typedef struct packed {
        logic rd_tgl;
        logic wr_tgl;
        logic [spihp_pkg::ADDR_W-1:0] rd_addr;
        logic [spihp_pkg::ADDR_W-1:0] wr_addr;
        logic [spihp_pkg::BYTE_W-1:0] wdata;
    } spihp_pay_s;

    typedef struct packed {
        logic [spihp_pkg::BYTE_W-1:0] tx;
        logic oe;
    } spihp_tx_s;

    spihp_core_s core;
    spihp_core_s next_core;
    spihp_ctl_s ctl;
    spihp_ctl_s next_ctl;
    spihp_pay_s pay;
    spihp_pay_s next_pay;
    spihp_tx_s txq;
    spihp_tx_s next_txq;
    logic frame_rst;
    logic [7:0] strap_raw;
    logic [spihp_pkg::BYTE_W-1:0] rx_byte;

    // Pin order gives address bit 0 from pin six up to bit 5 from pin one
    assign strap_raw = {link.iface_sel_strap, link.address_mode_strap,
                        link.port_pin_low[0], link.port_pin_low[1],
                        link.port_pin_low[2], link.port_pin_low[3],
                        link.port_pin_five, link.port_pin_six};

    // ***************************************************************
    // System clock side: detection and register space
    // ***************************************************************
    always_comb begin
        next_core = core;
        next_core.wr_strobe = 1'b0;
        next_core.strap_s1 = strap_raw;
        next_core.strap_s2 = core.strap_s1;
        if (!core.detected) begin
            // Latched once, later strap changes are ignored
            if (core.settle == 2'(spihp_pkg::STRAP_SETTLE - 1)) begin
                next_core.detected = 1'b1;
                if (core.strap_s2[spihp_pkg::STRAP_SEL_BIT]) begin
                    next_core.iface = spihp_pkg::SPIHP_IF_I2C;
                end else if (core.strap_s2[spihp_pkg::STRAP_MODE_BIT]) begin
                    next_core.iface = spihp_pkg::SPIHP_IF_SPI;
                    next_core.spi_on = 1'b1;
                end else begin
                    next_core.iface = spihp_pkg::SPIHP_IF_UART;
                end
                if (core.strap_s2[spihp_pkg::STRAP_MODE_BIT]) begin
                    next_core.i2c_addr = {1'b0, core.strap_s2[5:0]};
                end else begin
                    next_core.i2c_addr = {spihp_pkg::I2C_FIXED_HI, core.strap_s2[2:0]};
                end
            end else begin
                next_core.settle = core.settle + 2'd1;
            end
        end
        next_core.rd_sync = {core.rd_sync[1:0], pay.rd_tgl};
        next_core.wr_sync = {core.wr_sync[1:0], pay.wr_tgl};
        // Payload is stable once its toggle has crossed
        if (core.rd_sync[2] ^ core.rd_sync[1]) begin
            next_core.rd_word = core.regs[pay.rd_addr];
        end
        if (core.wr_sync[2] ^ core.wr_sync[1]) begin
            next_core.regs[pay.wr_addr] = pay.wdata;
            next_core.wr_strobe = 1'b1;
            next_core.wr_addr = pay.wr_addr;
            next_core.wr_data = pay.wdata;
        end
    end

    // Only reset_i clears detection and storage; frame resets leave them
    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            core <= '0;
        end else begin
            core <= next_core;
        end
    end

    // ***************************************************************
    // Link side: serial slave on the host's clock
    // ***************************************************************
    // Chip select high ends the frame; link idles unless SPI was chosen
    assign frame_rst = reset_i | link.sda_pin | ~core.spi_on;
    assign rx_byte = {ctl.shift[6:0], link.port_pin_six};

    always_comb begin
        next_ctl = ctl;
        next_pay = pay;
        next_ctl.shift = rx_byte;
        next_ctl.bit_cnt = ctl.bit_cnt + 3'd1;
        // Bit 0 of an address is always 0, so the address is known a bit
        // early; that extra period buys the crossing time
        if (ctl.bit_cnt == 3'd6 &&
            (ctl.addr_done ? ctl.is_read : ctl.shift[5])) begin
            next_pay.rd_addr = rx_byte[spihp_pkg::ADDR_W-1:0];
            next_pay.rd_tgl = ~pay.rd_tgl;
        end
        if (ctl.bit_cnt == 3'd7) begin
            if (!ctl.addr_done) begin
                next_ctl.addr_done = 1'b1;
                next_ctl.is_read = rx_byte[spihp_pkg::RW_BIT];
                next_ctl.addr = rx_byte[spihp_pkg::ADDR_MSB:spihp_pkg::ADDR_LSB];
            end else if (!ctl.is_read) begin
                next_pay.wr_addr = ctl.addr;
                next_pay.wdata = rx_byte;
                next_pay.wr_tgl = ~pay.wr_tgl;
            end
        end
    end

    // The serial clock is an input only
    always_ff @(posedge link.port_pin_five or posedge frame_rst) begin
        if (frame_rst) begin
            ctl <= '0;
        end else begin
            ctl <= next_ctl;
        end
    end

    always_ff @(posedge link.port_pin_five or posedge reset_i) begin
        if (reset_i) begin
            pay <= '0;
        end else begin
            pay <= next_pay;
        end
    end

    always_comb begin
        next_txq.oe = 1'b1;
        // New byte: load the word fetched during the previous slot
        if (ctl.bit_cnt == 3'd0) begin
            next_txq.tx = core.rd_word;
        end else begin
            next_txq.tx = {txq.tx[6:0], 1'b0};
        end
    end

    // MISO changes on the falling edge, and clears when the frame resets
    always_ff @(negedge link.port_pin_five or posedge frame_rst) begin
        if (frame_rst) begin
            txq <= '0;
        end else begin
            txq <= next_txq;
        end
    end

    // ***************************************************************
    // Pins and user outputs
    // ***************************************************************
    // UART transmit idles high; no UART framing lives here
    assign link.seven_drv = (core.iface == spihp_pkg::SPIHP_IF_UART) | txq.tx[7];
    assign link.seven_oe = (core.iface == spihp_pkg::SPIHP_IF_UART) | txq.oe;
    assign iface_type_o = core.iface;
    assign detect_done_o = core.detected;
    assign i2c_addr_o = core.i2c_addr;
    assign wr_strobe_o = core.wr_strobe;
    assign wr_addr_o = core.wr_addr;
    assign wr_data_o = core.wr_data;
endmodule

`default_nettype wire

// >>> src/spihp_host.sv
/*
 * Host end: SPI master that makes the serial clock from the system clock,
 * with a FIFO feeding write data.
 * Assumes the device answers MISO within one clock half period.
 */
`default_nettype none

module spihp_host #(
    parameter int unsigned HALF = spihp_pkg::HALF_DIV,
    parameter int unsigned DEPTH = spihp_pkg::FIFO_DEPTH
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    spihp_if.host link,
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire logic cmd_read_i,
    input wire logic [spihp_pkg::ADDR_W-1:0] cmd_addr_i,
    input wire logic [spihp_pkg::LEN_W-1:0] cmd_len_i,
    input wire logic wdata_valid_i,
    output logic wdata_ready_o,
    input wire logic [spihp_pkg::BYTE_W-1:0] wdata_i,
    output logic rdata_valid_o,
    output logic [spihp_pkg::BYTE_W-1:0] rdata_o
);
    typedef struct packed {
        spihp_pkg::spihp_hstate_e st;
        logic cs_n;
        logic sck;
        logic mosi;
        logic [7:0] div;
        logic [2:0] bits;
        logic [spihp_pkg::LEN_W-1:0] nbyte;
        logic [spihp_pkg::LEN_W-1:0] len;
        logic rd;
        logic [spihp_pkg::ADDR_W-1:0] addr;
        logic [7:0] tx;
        logic [7:0] rx;
        logic rv;
        logic [7:0] rdata;
        logic m1;
        logic m2;
        logic ready;
    } spihp_host_s;

    spihp_host_s q;
    spihp_host_s next_q;
    logic pop;
    logic fifo_valid;
    logic [spihp_pkg::BYTE_W-1:0] fifo_data;

    spihp_fifo #(.WIDTH(spihp_pkg::BYTE_W), .DEPTH(DEPTH)) u_wfifo (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .in_valid_i(wdata_valid_i),
        .in_ready_o(wdata_ready_o),
        .in_data_i(wdata_i),
        .out_valid_o(fifo_valid),
        .out_ready_i(pop),
        .out_data_o(fifo_data)
    );

    always_comb begin
        logic [spihp_pkg::LEN_W-1:0] k;
        k = q.nbyte + 6'd1;
        next_q = q;
        pop = 1'b0;
        next_q.rv = 1'b0;
        next_q.m1 = link.port_pin_seven;
        next_q.m2 = q.m1;
        case (q.st)
            spihp_pkg::HS_IDLE: begin
                next_q.ready = 1'b1;
                if (cmd_valid_i && q.ready) begin
                    next_q.ready = 1'b0;
                    next_q.rd = cmd_read_i;
                    next_q.addr = cmd_addr_i;
                    next_q.len = cmd_len_i;
                    next_q.tx = {cmd_read_i, cmd_addr_i, 1'b0};
                    next_q.mosi = cmd_read_i;
                    next_q.cs_n = 1'b0;
                    next_q.div = '0;
                    next_q.bits = '0;
                    next_q.nbyte = '0;
                    next_q.st = spihp_pkg::HS_SHIFT;
                end
            end
            spihp_pkg::HS_SHIFT: begin
                if (q.div == 8'(HALF - 1)) begin
                    next_q.div = '0;
                    if (!q.sck) begin
                        next_q.sck = 1'b1;
                    end else begin
                        // Synchronised MISO sampled late in the high phase
                        next_q.sck = 1'b0;
                        next_q.rx = {q.rx[6:0], q.m2};
                        next_q.bits = q.bits + 3'd1;
                        if (q.bits == 3'd7) begin
                            if (q.rd && q.nbyte != '0) begin
                                next_q.rv = 1'b1;
                                next_q.rdata = {q.rx[6:0], q.m2};
                            end
                            if (q.nbyte == q.len) begin
                                next_q.st = spihp_pkg::HS_END;
                            end else begin
                                next_q.nbyte = k;
                                if (q.rd) begin
                                    next_q.tx = (k < q.len) ?
                                        {1'b1, 6'(q.addr + k), 1'b0} :
                                        spihp_pkg::READ_END_BYTE;
                                    next_q.mosi = (k < q.len);
                                end else begin
                                    next_q.st = spihp_pkg::HS_WAIT;
                                end
                            end
                        end else begin
                            next_q.mosi = q.tx[6];
                            next_q.tx = {q.tx[6:0], 1'b0};
                        end
                    end
                end else begin
                    next_q.div = q.div + 8'd1;
                end
            end
            spihp_pkg::HS_WAIT: begin
                // Clock held low while the FIFO is empty
                if (fifo_valid) begin
                    pop = 1'b1;
                    next_q.tx = fifo_data;
                    next_q.mosi = fifo_data[7];
                    next_q.st = spihp_pkg::HS_SHIFT;
                end
            end
            spihp_pkg::HS_END: begin
                if (q.div == 8'(HALF - 1)) begin
                    next_q.div = '0;
                    next_q.cs_n = 1'b1;
                    next_q.st = spihp_pkg::HS_IDLE;
                end else begin
                    next_q.div = q.div + 8'd1;
                end
            end
            default: begin
                next_q.st = spihp_pkg::HS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            q <= '0;
            q.cs_n <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    assign link.sda_pin = q.cs_n;
    assign link.port_pin_five = q.sck;
    assign link.port_pin_six = q.mosi;
    assign cmd_ready_o = q.ready;
    assign rdata_valid_o = q.rv;
    assign rdata_o = q.rdata;
endmodule

`default_nettype wire

// >>> test/spihp_properties.sv
/*
 * Checker of the link between host end and device end.
 * Assumes one system clock, the host divider at HALF cycles per phase.
 */
`default_nettype none

module spihp_properties #(
    parameter int unsigned HALF = spihp_pkg::HALF_DIV
) (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic sda_pin,
    input wire logic port_pin_five,
    input wire logic port_pin_six,
    input wire logic seven_drv,
    input wire logic seven_oe,
    input wire logic port_pin_seven,
    input wire logic iface_sel_strap,
    input wire logic address_mode_strap,
    input wire logic [3:0] port_pin_low
);
    timeunit 1ns;
    timeprecision 100ps;

    // ****************
    // Helper counters
    // ****************
    logic [7:0] hi_cnt;
    logic [7:0] rise_cnt;
    logic sck_q;
    logic spi_strap;

    assign spi_strap = !iface_sel_strap && address_mode_strap;

    always_ff @(posedge clk_sys_i or posedge reset_i) begin
        if (reset_i) begin
            hi_cnt <= 8'h00;
            rise_cnt <= 8'h00;
            sck_q <= 1'b0;
        end else begin
            sck_q <= port_pin_five;
            hi_cnt <= port_pin_five ? hi_cnt + 8'h01 : 8'h00;
            if (sda_pin) begin
                rise_cnt <= 8'h00;
            end else if (port_pin_five && !sck_q) begin
                rise_cnt <= rise_cnt + 8'h01;
            end
        end
    end

    // ****************
    // Properties
    // ****************
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (reset_i);

    sequence cs_start;
        $fell(sda_pin);
    endsequence

    // Mode 0: clock low for one full phase before the first rise
    // Repeat count must track HALF; the bench runs the package divider
    sequence first_setup;
        !port_pin_five [*2] ##1 port_pin_five;
    endsequence

    chk_first_edge: assert property (cs_start |-> first_setup)
        else $error("first clock rise not one phase after select");
    chk_sck_half: assert property ($fell(port_pin_five) |-> hi_cnt == HALF)
        else $error("clock high phase has wrong length");
    chk_frame_bytes: assert property ($rose(sda_pin) |-> rise_cnt[2:0] == 3'h0)
        else $error("frame ended with a partial byte");
    chk_sck_idle: assert property (sda_pin |-> !port_pin_five)
        else $error("clock moved while deselected");
    chk_mosi_steady: assert property (port_pin_five && $past(port_pin_five)
        |-> $stable(port_pin_six))
        else $error("host data moved while clock high");
    chk_miso_steady: assert property (spi_strap && seven_oe && $past(seven_oe)
        && port_pin_five && $past(port_pin_five) |-> $stable(seven_drv))
        else $error("device data moved while clock high");
    chk_oe_released: assert property (spi_strap && sda_pin [*4] |-> !seven_oe)
        else $error("device drives data while deselected");
    chk_uart_tx_high: assert property (!iface_sel_strap && !address_mode_strap
        |-> port_pin_seven)
        else $error("transmit line not idle high");
endmodule

`default_nettype wire

// >>> test/spi_host_port_with_detect_tb.sv
/*
 * Testbench: host end and device end joined by the link, against a model.
 * Assumes package, interface and design modules are compiled first.
 */
`default_nettype none

module spi_host_port_with_detect_tb;
    timeunit 1ns;
    timeprecision 100ps;
    // Host divider at the package value, so the link runs at its top rate
    localparam int HALF = spihp_pkg::HALF_DIV;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic cmd_valid = 1'b0;
    logic cmd_read = 1'b0;
    logic [5:0] cmd_addr = 6'h00;
    logic [5:0] cmd_len = 6'h00;
    logic wdata_valid = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic cmd_ready, wdata_ready, rdata_valid, detect_done, wr_strobe;
    logic [7:0] rdata, wr_data;
    logic [6:0] i2c_addr;
    logic [5:0] wr_addr, a, n;
    spihp_pkg::spihp_iface_e iface_type, exp_if;
    logic [7:0] mem [64];
    logic [13:0] wq[$];
    logic [7:0] rq[$];
    int miscompares = 0;
    int num_checks = 0;
    int seed = 42;

    always #12.5 clk_sys_i = ~clk_sys_i;

    spihp_if link();
    spihp_device i_spihp_device(.clk_sys_i(clk_sys_i), .reset_i(reset_i), .link(link),
        .iface_type_o(iface_type), .detect_done_o(detect_done), .i2c_addr_o(i2c_addr),
        .wr_strobe_o(wr_strobe), .wr_addr_o(wr_addr), .wr_data_o(wr_data));
    spihp_host #(.HALF(HALF)) i_spihp_host(.clk_sys_i(clk_sys_i), .reset_i(reset_i),
        .link(link), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready),
        .cmd_read_i(cmd_read), .cmd_addr_i(cmd_addr), .cmd_len_i(cmd_len),
        .wdata_valid_i(wdata_valid), .wdata_ready_o(wdata_ready), .wdata_i(wdata),
        .rdata_valid_o(rdata_valid), .rdata_o(rdata));
    spihp_properties #(.HALF(HALF)) i_spihp_properties(.clk_sys_i(clk_sys_i),
        .reset_i(reset_i), .sda_pin(link.sda_pin), .port_pin_five(link.port_pin_five),
        .port_pin_six(link.port_pin_six), .seven_drv(link.seven_drv),
        .seven_oe(link.seven_oe), .port_pin_seven(link.port_pin_seven),
        .iface_sel_strap(link.iface_sel_strap),
        .address_mode_strap(link.address_mode_strap), .port_pin_low(link.port_pin_low));

    // ****************
    // Checking
    // ****************
    task check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task wrap_up();
        if (miscompares == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge clk_sys_i) begin
        if (wr_strobe === 1'b1) begin
            if (wq.size() == 0) check(16'hffff, 16'h0000);
            else check({2'h0, wr_addr, wr_data}, {2'h0, wq.pop_front()});
        end
        if (rdata_valid === 1'b1) begin
            if (rq.size() == 0) check(16'hffff, 16'h0000);
            else check({8'h00, rdata}, {8'h00, rq.pop_front()});
        end
    end

    // ****************
    // Drivers
    // ****************
    task do_reset(input logic sel, input logic mode);
        reset_i = 1'b1;
        link.iface_sel_strap = sel;
        link.address_mode_strap = mode;
        link.port_pin_low = 4'($random(seed));
        repeat (6) @(posedge clk_sys_i);
        #2 reset_i = 1'b0;
        repeat (5) @(posedge clk_sys_i);
        #2;
    endtask

    // Model learns the data only when the device listens on SPI
    task fill(input int cnt, input logic [5:0] adr, input bit spi);
        logic [7:0] d;
        for (int i = 0; i < cnt; i++) begin
            d = 8'($random(seed));
            wdata = d;
            wdata_valid = 1'b1;
            // A stuck handshake is left to the watchdog, which fails the run
            while (wdata_ready !== 1'b1) begin
                @(posedge clk_sys_i);
                #2;
            end
            @(posedge clk_sys_i);
            #2;
            if (spi) begin
                wq.push_back({adr, d});
                mem[adr] = d;
            end
        end
        wdata_valid = 1'b0;
    endtask

    task frame(input logic rd, input logic [5:0] adr, input logic [5:0] cnt);
        if (rd) for (int k = 0; k < cnt; k++) rq.push_back(mem[adr + k]);
        cmd_read = rd;
        cmd_addr = adr;
        cmd_len = cnt;
        cmd_valid = 1'b1;
        while (cmd_ready !== 1'b1) begin
            @(posedge clk_sys_i);
            #2;
        end
        @(posedge clk_sys_i);
        #2 cmd_valid = 1'b0;
        while (cmd_ready !== 1'b1) begin
            @(posedge clk_sys_i);
            #2;
        end
        repeat (8) @(posedge clk_sys_i);
        #2;
        check(16'(rq.size()), 16'h0000);
        check(16'(wq.size()), 16'h0000);
    endtask

    // ****************
    // Sequence
    // ****************
    initial begin
        link.iface_sel_strap = 1'b0;
        link.address_mode_strap = 1'b1;
        link.port_pin_low = 4'h0;
        for (int i = 0; i < 64; i++) mem[i] = 8'h00;
        // Modes in turn: uart, fixed-prefix i2c, pin i2c, spi last
        for (int m = 0; m < 4; m++) begin
            do_reset(m[0] ^ m[1], m[1]);
            exp_if = (m == 0) ? spihp_pkg::SPIHP_IF_UART :
                (m == 3) ? spihp_pkg::SPIHP_IF_SPI : spihp_pkg::SPIHP_IF_I2C;
            check({15'h0, detect_done}, 16'h0001);
            check({14'h0, iface_type}, {14'h0, exp_if});
            if (m == 0) check({15'h0, link.port_pin_seven}, 16'h0001);
            if (m == 1) check({9'h0, i2c_addr}, {9'h0, 4'h5, link.port_pin_low[3], 2'h0});
            if (m == 2) check({9'h0, i2c_addr}, {10'h0, link.port_pin_low[0],
                link.port_pin_low[1], link.port_pin_low[2], link.port_pin_low[3], 2'h0});
            if (m == 1 || m == 2) check({15'h0, link.seven_oe}, 16'h0000);
            if (m < 3) begin
                fill(1, 6'h05, 1'b0);
                frame(1'b0, 6'h05, 6'h01);
            end
        end
        repeat (6) begin
            a = 6'($random(seed)) % 6'd63;
            n = 6'(1 + ($random(seed) & 3));
            fill(n, a, 1'b1);
            frame(1'b0, a, n);
        end
        frame(1'b0, 6'h10, 6'h00);
        fill(32, a, 1'b1);
        check({15'h0, wdata_ready}, 16'h0000);
        frame(1'b0, a, 6'd32);
        frame(1'b1, 6'h00, 6'd63);
        // Strap moves after detection; port must keep working as SPI
        link.iface_sel_strap = 1'b1;
        frame(1'b1, a, 6'h01);
        check({14'h0, iface_type}, {14'h0, spihp_pkg::SPIHP_IF_SPI});
        // Reset after traffic must clear the register space
        do_reset(1'b0, 1'b1);
        for (int i = 0; i < 64; i++) mem[i] = 8'h00;
        check({14'h0, iface_type}, {14'h0, spihp_pkg::SPIHP_IF_SPI});
        frame(1'b1, a, 6'h02);
        wrap_up();
    end

    initial begin
        repeat (60000) @(posedge clk_sys_i);
        miscompares++;
        wrap_up();
    end
endmodule

`default_nettype wire
